// *** core/rss_clk_div.sv ***
// Purpose: System clock enable divider, oscillator rate over a power of two.
// Assumes: i_sel may change at any time; reserved codes are ignored.
// Notes: A new code is taken only at the end of a 32-cycle frame.
`timescale 1ns/100ps
module rss_clk_div (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_sel,
  output logic o_tick,
  output logic [2:0] o_active_sel
);

  logic [4:0] cnt;
  logic [4:0] mask;

  // The mask keeps the low bits of the counter that must be zero for a tick.
  assign mask = 5'(({1'b0, 5'h1F} << o_active_sel) >> 6'h0) ^ 5'h1F;

  // ----------------------------------------------------------------
  // Frame counter and code switch
  // ----------------------------------------------------------------
  // Switching only when the counter wraps keeps every period whole, so no
  // intermediate frequency appears; the wait is at most 32 cycles.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt <= 5'h00;
      o_active_sel <= rss_pkg::DIV_SEL_RESET;
    end else begin
      cnt <= cnt + 5'h01;
      if (cnt == 5'h1F && i_sel <= rss_pkg::DIV_SEL_MAX) begin
        o_active_sel <= i_sel;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= ((cnt + 5'h01) & mask) == 5'h00;
    end
  end

endmodule : rss_clk_div

// *** core/rss_pkg.sv ***
// Purpose: Shared constants and types of the reset and start-up sequencer.
// Assumes: A 40 MHz oscillator clock; all times are whole microseconds.
// Notes: Register addresses are byte addresses of aligned 32-bit words.
package rss_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int INIT_INTERVAL_US = 92;
  localparam int INIT_INTERVAL_CYC = INIT_INTERVAL_US * CLK_MHZ;
  localparam int STUP_16_US = 16;
  localparam int STUP_1024_US = 1024;
  localparam int STUP_2048_US = 2048;
  localparam int STUP_4096_US = 4096;
  localparam int STUP_16384_US = 16384;
  localparam int STUP_16_CYC = STUP_16_US * CLK_MHZ;
  localparam int STUP_1024_CYC = STUP_1024_US * CLK_MHZ;
  localparam int STUP_2048_CYC = STUP_2048_US * CLK_MHZ;
  localparam int STUP_4096_CYC = STUP_4096_US * CLK_MHZ;
  localparam int STUP_16384_CYC = STUP_16384_US * CLK_MHZ;
  localparam int CNT_W = 20;
  localparam int PULSE_STRETCH_CYC = 16;
  localparam int EXT_MIN_LOW_CYC = 2;

  // ----------------------------------------------------------------
  // Clock divider
  // ----------------------------------------------------------------
  localparam int DIV_SEL_W = 3;
  localparam logic [2:0] DIV_SEL_MAX = 3'h5;
  localparam int DIV_CNT_W = 5;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] CLOCK_CTRL_ADDR = 5'h00;
  localparam logic [4:0] POWER_CONTROL_ADDR = 5'h04;
  localparam logic [4:0] EVENT_STATUS_ADDR = 5'h08;
  localparam logic [4:0] EVENT_CLEAR_ADDR = 5'h0C;
  localparam logic [4:0] EVENT_ENABLE_ADDR = 5'h10;
  localparam logic [4:0] SEQ_STATE_ADDR = 5'h14;
  localparam int CLK_OUT_EN_BIT = 0;
  localparam int DIV_SEL_LSB = 1;
  localparam int POWER_OFF_FLAG_BIT = 0;
  localparam logic [2:0] DIV_SEL_RESET = 3'h0;
  localparam int EVT_W = 5;
  localparam int EVT_POR = 0;
  localparam int EVT_BRN = 1;
  localparam int EVT_EXT = 2;
  localparam int EVT_WDT = 3;
  localparam int EVT_SW = 4;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POR_HOLD,
    ST_INIT,
    ST_WAIT_BRN,
    ST_STARTUP,
    ST_EXT_HOLD,
    ST_RUN
  } rss_state_t;

endpackage : rss_pkg

// *** core/rss_sync.sv ***
// Purpose: Two flip-flop synchroniser for one asynchronous level.
// Assumes: The input may change at any time relative to i_clk.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/100ps
module rss_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_async,
  output logic o_sync
);

  logic meta;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta <= RESET_VAL;
      o_sync <= RESET_VAL;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule : rss_sync

// *** core/rss_top.sv ***
// Purpose: Reset sources, power-on and start-up timing, system clock divider.
// Assumes: Detector and pin inputs are asynchronous; watchdog, software and
//   wake-up requests are one-cycle pulses on i_clk.
// Notes: Registers are reached over Avalon-MM and are reset only by i_rst.
`timescale 1ns/100ps
module rss_top #(
  parameter int P_STUP_1024_CYC = rss_pkg::STUP_1024_CYC,
  parameter int P_STUP_2048_CYC = rss_pkg::STUP_2048_CYC,
  parameter int P_STUP_4096_CYC = rss_pkg::STUP_4096_CYC,
  parameter int P_STUP_16384_CYC = rss_pkg::STUP_16384_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_por_low,
  input wire logic i_brownout_low,
  input wire logic i_brownout_detector_en,
  input wire logic i_ext_rst_n,
  input wire logic i_ext_rst_pin_en,
  input wire logic i_wdt_timeout,
  input wire logic i_sw_reset,
  input wire logic i_pd_wake,
  input wire logic [1:0] i_startup_time_fuse,
  input wire logic i_clk_src_crystal,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_irq,
  output logic o_sys_reset,
  output logic o_port_tristate,
  output logic [15:0] o_pc_start,
  output logic o_sys_clk_en,
  output logic o_oscillator_pin_two,
  output logic o_oscillator_pin_two_oe
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic por_low;
  logic brn_low;
  logic ext_n;

  rss_sync #(.RESET_VAL(1'b1)) u_sync_por (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(i_por_low),
    .o_sync(por_low)
  );

  rss_sync #(.RESET_VAL(1'b1)) u_sync_brn (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(i_brownout_low),
    .o_sync(brn_low)
  );

  rss_sync #(.RESET_VAL(1'b1)) u_sync_ext (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(i_ext_rst_n),
    .o_sync(ext_n)
  );

  // ----------------------------------------------------------------
  // Source conditioning
  // ----------------------------------------------------------------
  logic ext_n_q;
  logic powerup_phase;
  logic ext_active;
  logic [4:0] pulse_cnt;
  logic brn_trip;

  // The pin must stay low for two sampled cycles before it counts.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ext_n_q <= 1'b1;
    end else begin
      ext_n_q <= ext_n;
    end
  end

  // During power-up the pin always acts as reset, whatever the fuse says.
  assign ext_active = !ext_n && !ext_n_q && (i_ext_rst_pin_en || powerup_phase);
  assign brn_trip = i_brownout_detector_en && brn_low;

  // Watchdog and software requests become a 16-cycle reset pulse.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pulse_cnt <= 5'h00;
    end else if (i_wdt_timeout || i_sw_reset) begin
      pulse_cnt <= 5'(rss_pkg::PULSE_STRETCH_CYC);
    end else if (pulse_cnt != 5'h00) begin
      pulse_cnt <= pulse_cnt - 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Start-up delay selection
  // ----------------------------------------------------------------
  logic [19:0] stup_cycles;

  always_comb begin
    case (i_startup_time_fuse)
      2'h0: begin
        stup_cycles = i_clk_src_crystal ? 20'(P_STUP_1024_CYC) : 20'(rss_pkg::STUP_16_CYC);
      end
      2'h1: begin
        stup_cycles = 20'(P_STUP_2048_CYC);
      end
      2'h2: begin
        stup_cycles = i_clk_src_crystal ? 20'(P_STUP_4096_CYC) : 20'(P_STUP_1024_CYC);
      end
      default: begin
        stup_cycles = 20'(P_STUP_16384_CYC);
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  rss_pkg::rss_state_t state;
  rss_pkg::rss_state_t next_state;
  logic [19:0] cnt;
  logic init_done;

  assign init_done = cnt >= 20'(rss_pkg::INIT_INTERVAL_CYC - 1);

  always_comb begin
    next_state = state;
    case (state)
      rss_pkg::ST_POR_HOLD: begin
        if (!por_low) begin
          next_state = rss_pkg::ST_INIT;
        end
      end
      rss_pkg::ST_INIT: begin
        if (init_done) begin
          next_state = brn_trip ? rss_pkg::ST_WAIT_BRN : rss_pkg::ST_STARTUP;
        end
      end
      rss_pkg::ST_WAIT_BRN: begin
        if (!brn_trip) begin
          next_state = rss_pkg::ST_STARTUP;
        end
      end
      rss_pkg::ST_STARTUP: begin
        if (brn_trip) begin
          next_state = rss_pkg::ST_WAIT_BRN;
        end else if (cnt >= stup_cycles - 20'h1) begin
          next_state = ext_active ? rss_pkg::ST_EXT_HOLD : rss_pkg::ST_RUN;
        end
      end
      rss_pkg::ST_EXT_HOLD: begin
        if (brn_trip) begin
          next_state = rss_pkg::ST_WAIT_BRN;
        end else if (ext_n) begin
          next_state = rss_pkg::ST_RUN;
        end
      end
      rss_pkg::ST_RUN: begin
        if (brn_trip) begin
          next_state = rss_pkg::ST_WAIT_BRN;
        end else if (i_pd_wake) begin
          next_state = rss_pkg::ST_STARTUP;
        end
      end
      default: begin
        next_state = rss_pkg::ST_POR_HOLD;
      end
    endcase
    if (por_low) begin
      next_state = rss_pkg::ST_POR_HOLD;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= rss_pkg::ST_POR_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // One counter serves the init interval and the start-up timer.
  always_ff @(posedge i_clk) begin
    if (i_rst || next_state != state) begin
      cnt <= 20'h00000;
    end else if (state == rss_pkg::ST_INIT || state == rss_pkg::ST_STARTUP) begin
      cnt <= cnt + 20'h00001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || state == rss_pkg::ST_POR_HOLD) begin
      powerup_phase <= 1'b1;
    end else if (state == rss_pkg::ST_RUN) begin
      powerup_phase <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Internal reset and reset-state outputs
  // ----------------------------------------------------------------
  logic any_reset;

  assign any_reset = (next_state != rss_pkg::ST_RUN) || ext_active || (pulse_cnt != 5'h00);

  // Registered so that release is aligned to i_clk whichever source ends last.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sys_reset <= 1'b1;
      o_port_tristate <= 1'b1;
      o_pc_start <= rss_pkg::RESET_VECTOR;
    end else begin
      o_sys_reset <= any_reset;
      o_port_tristate <= any_reset;
      o_pc_start <= rss_pkg::RESET_VECTOR;
    end
  end

  // ----------------------------------------------------------------
  // Clock divider and clock output
  // ----------------------------------------------------------------
  logic [2:0] div_sel;
  logic clk_out_en;
  logic div_tick;
  logic sys_half;

  rss_clk_div u_div (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_sel(div_sel),
    .o_tick(div_tick),
    .o_active_sel()
  );

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_sys_clk_en <= 1'b0;
      sys_half <= 1'b0;
    end else begin
      o_sys_clk_en <= div_tick;
      if (div_tick) begin
        sys_half <= !sys_half;
      end
    end
  end

  // The pin is released during reset; software owns the clock output enable.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_oscillator_pin_two <= 1'b0;
      o_oscillator_pin_two_oe <= 1'b0;
    end else begin
      o_oscillator_pin_two <= sys_half;
      o_oscillator_pin_two_oe <= clk_out_en && !any_reset;
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  logic req;
  logic wr_now;
  logic power_off_flag;
  logic [4:0] evt_status;
  logic [4:0] evt_enable;
  logic [4:0] evt_set;
  logic [4:0] evt_clr;
  logic poff_clr;

  // A request waits one cycle; data and write effect land on the free cycle.
  assign req = (i_avs_read || i_avs_write) && o_avs_waitrequest;
  assign wr_now = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !req;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_avs_readdata <= 32'h00000000;
    end else if (req && i_avs_read) begin
      case (i_avs_address & 5'h1C)
        rss_pkg::CLOCK_CTRL_ADDR: begin
          o_avs_readdata <= {28'h0000000, div_sel, clk_out_en};
        end
        rss_pkg::POWER_CONTROL_ADDR: begin
          o_avs_readdata <= {31'h00000000, power_off_flag};
        end
        rss_pkg::EVENT_STATUS_ADDR: begin
          o_avs_readdata <= {27'h0000000, evt_status};
        end
        rss_pkg::EVENT_ENABLE_ADDR: begin
          o_avs_readdata <= {27'h0000000, evt_enable};
        end
        rss_pkg::SEQ_STATE_ADDR: begin
          o_avs_readdata <= {27'h0000000, any_reset, 1'b0, state};
        end
        default: begin
          o_avs_readdata <= 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_sel <= rss_pkg::DIV_SEL_RESET;
      clk_out_en <= 1'b0;
      evt_enable <= 5'h00;
    end else if (wr_now) begin
      if ((i_avs_address & 5'h1C) == rss_pkg::CLOCK_CTRL_ADDR) begin
        div_sel <= i_avs_writedata[rss_pkg::DIV_SEL_LSB +: rss_pkg::DIV_SEL_W];
        clk_out_en <= i_avs_writedata[rss_pkg::CLK_OUT_EN_BIT];
      end
      if ((i_avs_address & 5'h1C) == rss_pkg::EVENT_ENABLE_ADDR) begin
        evt_enable <= i_avs_writedata[rss_pkg::EVT_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Power-off flag and reset-source events
  // ----------------------------------------------------------------
  assign poff_clr = wr_now && (i_avs_address & 5'h1C) == rss_pkg::POWER_CONTROL_ADDR &&
                   i_avs_writedata[rss_pkg::POWER_OFF_FLAG_BIT];
  assign evt_clr = (wr_now && (i_avs_address & 5'h1C) == rss_pkg::EVENT_CLEAR_ADDR) ?
                   i_avs_writedata[rss_pkg::EVT_W-1:0] : 5'h00;

  always_comb begin
    evt_set = 5'h00;
    evt_set[rss_pkg::EVT_POR] = por_low;
    evt_set[rss_pkg::EVT_BRN] = brn_trip;
    evt_set[rss_pkg::EVT_EXT] = ext_active;
    evt_set[rss_pkg::EVT_WDT] = i_wdt_timeout;
    evt_set[rss_pkg::EVT_SW] = i_sw_reset;
  end

  // Set wins over a clear in the same cycle so no event is lost.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      power_off_flag <= 1'b0;
    end else if (por_low) begin
      power_off_flag <= 1'b1;
    end else if (poff_clr) begin
      power_off_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      evt_status <= 5'h00;
      o_irq <= 1'b0;
    end else begin
      evt_status <= (evt_status & ~evt_clr) | evt_set;
      o_irq <= |(((evt_status & ~evt_clr) | evt_set) & evt_enable);
    end
  end

endmodule : rss_top

// *** test/rss_checker.sv ***
// Purpose: Port-level checks of the reset and start-up sequencer.
// Assumes: One clock domain; i_rst is synchronous and active high.
// Notes: Bound to rss_top at the foot of this file.
`timescale 1ns/100ps
module rss_checker (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_por_low,
  input wire logic i_brownout_low,
  input wire logic i_brownout_detector_en,
  input wire logic i_ext_rst_n,
  input wire logic i_ext_rst_pin_en,
  input wire logic i_wdt_timeout,
  input wire logic i_sw_reset,
  input wire logic o_sys_reset,
  input wire logic o_port_tristate,
  input wire logic [15:0] o_pc_start,
  input wire logic o_sys_clk_en,
  input wire logic o_oscillator_pin_two,
  input wire logic o_oscillator_pin_two_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  // Cycles since the last system tick; a stuck divider shows up as a long gap.
  logic [5:0] tick_gap;
  always_ff @(posedge i_clk) begin
    if (i_rst || o_sys_reset || o_sys_clk_en) begin
      tick_gap <= 6'h00;
    end else if (tick_gap != 6'h3F) begin
      tick_gap <= tick_gap + 6'h01;
    end
  end

  sequence s_pulse16;
    o_sys_reset [*8] ##1 o_sys_reset [*8];
  endsequence

  sequence s_tick_shown;
    o_sys_clk_en && o_oscillator_pin_two_oe ##1 o_oscillator_pin_two_oe;
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  tristate_match_a: assert property (o_port_tristate == o_sys_reset)
    else $error("port tristate differs from internal reset");
  reset_vector_a: assert property (o_pc_start == 16'h0000)
    else $error("start address is not the reset vector");
  por_reassert_a: assert property (i_por_low |-> ##[1:4] o_sys_reset)
    else $error("low supply did not reassert reset");
  init_hold_a: assert property ($fell(i_por_low) |-> o_sys_reset [*8])
    else $error("reset released right after supply rise");
  pulse_reset_a: assert property (
    (i_wdt_timeout || i_sw_reset) && !o_sys_reset |-> ##2 s_pulse16 ##1 !o_sys_reset)
    else $error("reset pulse shorter than sixteen cycles");
  ext_hold_a: assert property (
    (i_ext_rst_pin_en && !i_ext_rst_n) [*8] |-> o_sys_reset)
    else $error("low reset pin did not hold reset");
  clk_out_gate_a: assert property (
    o_sys_reset ##1 o_sys_reset |-> !o_oscillator_pin_two_oe)
    else $error("clock output driven during reset");
  pin_toggle_a: assert property (
    s_tick_shown |-> o_oscillator_pin_two != $past(o_oscillator_pin_two))
    else $error("clock output did not toggle on a system tick");
  tick_gap_a: assert property (tick_gap < 6'd33)
    else $error("system tick gap above thirty-two cycles");
  release_clean_a: assert property ($fell(o_sys_reset) |->
    !$past(i_por_low, 3) && !$past(i_wdt_timeout) && !$past(i_sw_reset) &&
    !(i_brownout_detector_en && $past(i_brownout_low, 3)))
    else $error("reset released while a source was active");
endmodule : rss_checker

bind rss_top rss_checker i_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_por_low(i_por_low),
  .i_brownout_low(i_brownout_low), .i_brownout_detector_en(i_brownout_detector_en),
  .i_ext_rst_n(i_ext_rst_n), .i_ext_rst_pin_en(i_ext_rst_pin_en),
  .i_wdt_timeout(i_wdt_timeout), .i_sw_reset(i_sw_reset), .o_sys_reset(o_sys_reset),
  .o_port_tristate(o_port_tristate), .o_pc_start(o_pc_start), .o_sys_clk_en(o_sys_clk_en),
  .o_oscillator_pin_two(o_oscillator_pin_two),
  .o_oscillator_pin_two_oe(o_oscillator_pin_two_oe)
);

// *** test/rss_tb_top.sv ***
// Purpose: Self-checking bench of the reset and start-up sequencer.
// Assumes: Shortened start-up counts through the top parameters.
// Notes: Reset spans are measured in cycles and bounded by the model.
`timescale 1ns/100ps
module reset_startup_sequencer_tb_top;
  localparam int P1 = 50;
  localparam int P2 = 60;
  localparam int P3 = 70;
  localparam int P4 = 80;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_por_low = 1'b1;
  logic i_brownout_low = 1'b1;
  logic i_brn_en = 1'b1;
  logic i_pd_wake = 1'b0;
  logic i_ext_rst_n = 1'b1;
  logic i_wdt_timeout = 1'b0;
  logic i_sw_reset = 1'b0;
  logic [1:0] i_fuse = 2'h0;
  logic i_xtal = 1'b1;
  logic [4:0] i_avs_address = 5'h00;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0000_0000;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest, o_irq, o_sys_reset, o_port_tristate;
  logic o_sys_clk_en, o_oscillator_pin_two, o_oscillator_pin_two_oe;
  logic [15:0] o_pc_start;
  logic [31:0] q;
  logic p0, p1;
  int fails = 0;
  int tests_run = 0;
  int n, g, e;

  always #12.5 i_clk = ~i_clk;

  rss_top #(.P_STUP_1024_CYC(P1), .P_STUP_2048_CYC(P2), .P_STUP_4096_CYC(P3),
    .P_STUP_16384_CYC(P4)) i_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_por_low(i_por_low), .i_brownout_low(i_brownout_low),
    .i_brownout_detector_en(i_brn_en), .i_ext_rst_n(i_ext_rst_n), .i_ext_rst_pin_en(1'b1),
    .i_wdt_timeout(i_wdt_timeout), .i_sw_reset(i_sw_reset), .i_pd_wake(i_pd_wake),
    .i_startup_time_fuse(i_fuse), .i_clk_src_crystal(i_xtal), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(4'hF), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_irq(o_irq), .o_sys_reset(o_sys_reset),
    .o_port_tristate(o_port_tristate), .o_pc_start(o_pc_start), .o_sys_clk_en(o_sys_clk_en),
    .o_oscillator_pin_two(o_oscillator_pin_two),
    .o_oscillator_pin_two_oe(o_oscillator_pin_two_oe)
  );

  // ----------------------------------------------------------------
  // Model and helpers
  // ----------------------------------------------------------------
  function automatic int stup_exp(input int code, input bit x);
    case (code)
      0: return x ? P1 : rss_pkg::STUP_16_CYC;
      1: return P2;
      2: return x ? P3 : P1;
      default: return P4;
    endcase
  endfunction : stup_exp

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic chk_span(input string what, input int lo, input int hi, input int got);
    tests_run++;
    if (got < lo || got > hi) begin
      fails++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_span

  // Holds the request until waitrequest is sampled low, then releases it.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_avs_read <= !wr;
    i_avs_write <= wr;
    i_avs_address <= a;
    i_avs_writedata <= d;
    do begin
      @(posedge i_clk);
    end while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask : bus

  task automatic count_rst(output int c);
    c = 0;
    while (o_sys_reset === 1'b1 && c < 200000) begin
      @(posedge i_clk);
      c++;
    end
  endtask : count_rst

  task automatic tick_gap(output int c);
    int k;
    k = 0;
    c = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_sys_clk_en !== 1'b1 && k < 100);
    p0 = o_oscillator_pin_two;
    do begin
      @(posedge i_clk);
      c++;
    end while (o_sys_clk_en !== 1'b1 && c < 100);
    p1 = o_oscillator_pin_two;
  endtask : tick_gap

  task automatic results();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge i_clk);
    fails++;
    results();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(38));
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_por_low <= 1'b0;
    repeat (1000) @(posedge i_clk);
    chk("tristate", 1, o_port_tristate);
    chk("vector", 0, o_pc_start);
    i_brownout_low <= 1'b0;
    count_rst(n);
    e = rss_pkg::INIT_INTERVAL_CYC + P1;
    chk_span("power-up span", e, e + 10, n + 1000);
    chk("tristate run", 0, o_port_tristate);
    bus(0, rss_pkg::POWER_CONTROL_ADDR, 0);
    chk("power off flag", 1, q);
    bus(0, rss_pkg::EVENT_STATUS_ADDR, 0);
    chk("status power-up", 32'h0000_0003, q);
    bus(1, rss_pkg::EVENT_CLEAR_ADDR, 32'h0000_001F);
    bus(1, rss_pkg::POWER_CONTROL_ADDR, 32'h0000_0001);
    bus(0, rss_pkg::POWER_CONTROL_ADDR, 0);
    chk("power off clear", 0, q);
    bus(0, 5'h18, 0);
    chk("unmapped", 0, q);
    for (int c = 0; c < 8; c++) begin
      i_fuse <= c[2:1];
      i_xtal <= c[0];
      i_brownout_low <= 1'b1;
      repeat (6) @(posedge i_clk);
      i_brownout_low <= 1'b0;
      count_rst(n);
      e = stup_exp(c / 2, c[0]);
      chk_span("brown-out span", e, e + 8, n);
    end
    bus(1, rss_pkg::EVENT_ENABLE_ADDR, 32'h0000_0002);
    repeat (2) @(posedge i_clk);
    chk("irq set", 1, o_irq);
    bus(1, rss_pkg::EVENT_ENABLE_ADDR, 32'h0000_0000);
    repeat (2) @(posedge i_clk);
    chk("irq masked", 0, o_irq);
    bus(1, rss_pkg::EVENT_ENABLE_ADDR, 32'h0000_0002);
    bus(1, rss_pkg::EVENT_CLEAR_ADDR, 32'h0000_0002);
    repeat (2) @(posedge i_clk);
    chk("irq cleared", 0, o_irq);
    i_fuse <= 2'h0;
    i_xtal <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      @(posedge i_clk);
      i_wdt_timeout <= (s == 0);
      i_sw_reset <= (s == 1);
      @(posedge i_clk);
      i_wdt_timeout <= 1'b0;
      i_sw_reset <= 1'b0;
      repeat (2) @(posedge i_clk);
      count_rst(n);
      chk_span("pulse span", 16, 16, n);
    end
    bus(0, rss_pkg::EVENT_STATUS_ADDR, 0);
    chk("status pulses", 32'h0000_0018, q);
    @(posedge i_clk);
    i_pd_wake <= 1'b1;
    @(posedge i_clk);
    i_pd_wake <= 1'b0;
    @(posedge i_clk);
    count_rst(n);
    e = stup_exp(0, 1);
    chk_span("wake span", e - 1, e + 1, n);
    i_ext_rst_n <= 1'b0;
    i_brownout_low <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_brownout_low <= 1'b0;
    repeat (P1 + 20 + ($urandom % 40)) @(posedge i_clk);
    chk("pin hold", 1, o_sys_reset);
    i_ext_rst_n <= 1'b1;
    count_rst(n);
    chk_span("pin release", 0, P1 + 10, n);
    bus(0, rss_pkg::EVENT_STATUS_ADDR, 0);
    chk("status pin", 32'h0000_001E, q);
    i_xtal <= 1'b0;
    for (int d = 0; d < 7; d++) begin
      bus(1, rss_pkg::CLOCK_CTRL_ADDR, {28'($urandom), d[2:0], 1'b1});
      repeat (40) @(posedge i_clk);
      tick_gap(g);
      chk_span("tick gap", 1 << ((d > 5) ? 5 : d), 1 << ((d > 5) ? 5 : d), g);
      chk("pin two toggle", {31'h0, ~p0}, {31'h0, p1});
      chk("pin two enable", 1, o_oscillator_pin_two_oe);
    end
    i_brn_en <= 1'b0;
    i_por_low <= 1'b1;
    repeat (5) @(posedge i_clk);
    chk("por reassert", 1, o_sys_reset);
    chk("pin two in reset", 0, o_oscillator_pin_two_oe);
    i_por_low <= 1'b0;
    count_rst(n);
    e = rss_pkg::INIT_INTERVAL_CYC + stup_exp(0, 0);
    chk_span("cold span", e, e + 8, n);
    bus(0, rss_pkg::POWER_CONTROL_ADDR, 0);
    chk("power off again", 1, q);
    bus(1, rss_pkg::CLOCK_CTRL_ADDR, 32'h0000_0000);
    repeat (3) @(posedge i_clk);
    chk("pin two off", 0, o_oscillator_pin_two_oe);
    results();
  end
endmodule : reset_startup_sequencer_tb_top
